/* File: design/lspm_pkg.sv */
// Package of constants and types for the LCD scan and power mode controller.
package lspm_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_HZ = 25000000; // System clock rate in hertz.
    localparam int POR_WAIT_MS = 5; // Supply settle wait, low end of 5..10 ms.
    // Cycles per millisecond round down to whole cycles.
    localparam int POR_WAIT_CYC = (POR_WAIT_MS * (CLK_HZ / 1000));
    localparam int RESET_PROC_CYC = 16; // Length of the internal reset process.
    localparam int ROW_DIV_DEFAULT = 64; // Clocks per row period by default.

    // ****************************************
    // Scan geometry
    // ****************************************
    localparam int LINE_W = 7; // RAM line address width.
    localparam logic [7:0] MUX_64 = 8'h40; // Active rows, setting 0.
    localparam logic [7:0] MUX_80 = 8'h50; // Active rows, setting 1.
    localparam logic [7:0] MUX_102 = 8'h66; // Active rows, setting 2.
    localparam logic [7:0] MUX_128 = 8'h80; // Active rows, setting 3.

    // ****************************************
    // Reset values of control state
    // ****************************************
    localparam logic [1:0] MUX_RATE_RST = 2'h3; // Default mux setting.
    localparam logic [6:0] START_LINE_RST = 7'h00; // Default start line.
    localparam logic MIRROR_RST = 1'b0; // Default row mirror.
    localparam logic [2:0] DRV_EN_RST = 3'h0; // Default driver enable.
    localparam logic [2:0] DRV_ALL_OFF = 3'h0; // Driver field for sleep.
    localparam logic [2:0] DRV_ALL_ON = 3'h7; // Driver field for normal.

    // Operating mode codes, Gray order reset, sleep, normal.
    typedef enum logic [1:0] {
        LSPM_MODE_RESET = 2'b00,
        LSPM_MODE_SLEEP = 2'b10,
        LSPM_MODE_NORMAL = 2'b11
    } lspm_mode_e;

    // Active row count for a mux setting.
    function automatic logic [7:0] lspm_mux_rows(input logic [1:0] sel);
        logic [7:0] r;
        r = MUX_128;
        case (sel)
            2'h0: r = MUX_64;
            2'h1: r = MUX_80;
            2'h2: r = MUX_102;
            default: r = MUX_128;
        endcase
        return r;
    endfunction

endpackage

/* File: design/lspm_line_gen.sv */
// Row scan counter and RAM line address generator.
module lspm_line_gen
    import lspm_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic run, // Scan runs only while high.
    input wire logic row_tick, // One-cycle pulse, one per row period.
    input wire logic [1:0] mux_rate_setting, // Mux rate select.
    input wire logic [6:0] scan_start_line, // Start line.
    input wire logic row_mirror, // Row mirror enable.
    output logic [7:0] row_index, // Physical row being scanned, zero based.
    output logic [6:0] ram_line, // RAM line for this row.
    output logic field_start // High during the first row of a field.
);
    logic [7:0] rows;
    logic [7:0] last_row;
    logic [6:0] first_line;

    // First line of a field follows the current settings.
    always_comb begin
        rows = lspm_mux_rows(mux_rate_setting);
        last_row = rows - 8'h01;
        if (row_mirror) begin
            first_line = scan_start_line + last_row[6:0];
        end else begin
            first_line = scan_start_line;
        end
    end

    // The physical order never depends on start line or mirror.
    always_ff @(posedge clock) begin
        if (rst || !run) begin
            row_index <= 8'h00;
        end else if (row_tick) begin
            if (row_index >= last_row) begin
                row_index <= 8'h00;
            end else begin
                row_index <= row_index + 8'h01;
            end
        end
    end

    // Line address steps once per row and reloads at each field start.
    always_ff @(posedge clock) begin
        if (rst || !run) begin
            ram_line <= first_line;
        end else if (row_tick) begin
            if (row_index >= last_row) begin
                ram_line <= first_line;
            end else if (row_mirror) begin
                ram_line <= ram_line - 7'h01;
            end else begin
                ram_line <= ram_line + 7'h01;
            end
        end
    end

    assign field_start = (row_index == 8'h00);

    // The reload uses the start line seen at the reload edge.
    a_line_first: assert property (
        @(posedge clock) disable iff (rst)
        (run && row_tick && row_index >= last_row && !row_mirror)
        |=> ram_line == $past(scan_start_line))
        else $error("first line not start line");

    a_line_step: assert property (
        @(posedge clock) disable iff (rst)
        (run && row_tick && row_index < last_row && row_mirror) ##1 run
        |-> ram_line == $past(ram_line) - 7'h01)
        else $error("mirror step wrong");

    a_row_wrap: assert property (
        @(posedge clock) disable iff (rst)
        row_index <= 8'h7f)
        else $error("row index out of range");

endmodule

/* File: design/lspm_ctrl.sv */
// Top of the LCD scan and power mode controller.
// ****************************************
// Mode control, reset sequencing and scan wiring
// ****************************************

// Notes on behaviour
// - Rows scan at frame rate times mux
// - Field runs first row to last active
// - Physical row order never changes
// - Start line maps first row to slice
// - Unmirrored lines count up modulo 128
// - Mirrored first line is start plus mux-1
// - Mirrored lines count down modulo 128
// - Mirror changes mapping only, not RAM
// - Power-on waits then triggers reset
// - Reset command or pin also resets
// - Reset mode, status and busy held
// - During reset only status read accepted
// - Reset restores control defaults
// - Mode codes 00, 10, 11
// - Clock, drivers, pump only in normal
// - Driver field selects sleep or normal
// - Only reset drains the capacitors
// - Drivers idle until supplies ready
module lspm_ctrl
    import lspm_pkg::*;
#(
    parameter int POR_CYCLES = POR_WAIT_CYC // Power-on wait in clocks.
)
(
    input wire logic clock, // System clock, 25 MHz.
    input wire logic rst, // Power-on reset, synchronous, active high.
    input wire logic reset_pin_n, // External reset pin, active low.
    input wire logic cmd_valid, // One-cycle command strobe.
    input wire logic cmd_is_status_read, // Command is a status read.
    input wire logic cmd_sys_reset, // Command is a system reset.
    input wire logic cmd_set_mux, // Command sets the mux rate.
    input wire logic cmd_set_start, // Command sets the start line.
    input wire logic cmd_set_map, // Command sets the mapping bits.
    input wire logic cmd_set_enable, // Command sets the driver field.
    input wire logic [7:0] cmd_arg, // Command argument.
    input wire logic [7:0] row_div, // Clocks per row period minus one.
    input wire logic supplies_ready, // Panel supply and bias are ready.
    output logic status_valid, // Status read answered.
    output logic [3:0] status_data, // Reset, busy and mode bits.
    output logic reset_in_progress_flag, // Reset process under way.
    output logic busy_flag, // Device busy.
    output lspm_mode_e operating_mode_field, // Operating mode.
    output logic [1:0] mux_rate_setting, // Current mux setting.
    output logic [6:0] scan_start_line, // Current start line.
    output logic row_mirror, // Current row mirror.
    output logic [2:0] driver_enable_field, // Current driver field.
    output logic display_clk_en, // Display clock gate.
    output logic drivers_active, // Row and column drivers active.
    output logic pump_en, // Charge pump enable.
    output logic drain_en, // Draining circuit enable.
    output logic row_tick, // Row period pulse.
    output logic [7:0] row_index, // Physical row being scanned.
    output logic [6:0] ram_line, // RAM line to read.
    output logic field_start // First row of a field.
);
    // ****************************************
    // Declarations
    // ****************************************
    // One clock drives every register below.
    logic pin_meta_reg; // First synchroniser stage of the pin.
    logic pin_sync_reg; // Second stage, safe to read.
    logic [31:0] por_cnt_reg; // Power-on wait counter.
    logic por_done_reg; // Power-on wait has ended.
    logic [7:0] rp_cnt_reg; // Reset process counter.
    logic sys_reset_reg; // Reset process running.
    logic start_reset; // Request to start a reset.
    logic cmd_take; // Command accepted.
    logic [7:0] div_cnt_reg; // Row divider.
    logic ready_reg; // Supplies confirmed since leaving idle.

    // The reset pin is asynchronous, so it passes two flops first.
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= reset_pin_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ****************************************
    // Reset sources
    // ****************************************

    // Power-on waits for the supply before starting a system reset.
    // The counter stops once done, so it never wraps.
    always_ff @(posedge clock) begin
        if (rst) begin
            por_cnt_reg <= 32'h0;
            por_done_reg <= 1'b0;
        end else if (!por_done_reg) begin
            if (por_cnt_reg >= 32'(POR_CYCLES - 1)) begin
                por_done_reg <= 1'b1;
            end else begin
                por_cnt_reg <= por_cnt_reg + 32'h1;
            end
        end
    end

    // Commands are dropped silently while reset runs; status reads pass.
    assign cmd_take = cmd_valid && (!sys_reset_reg || cmd_is_status_read);

    // Pin, command or the end of the power-on wait start a reset.
    // The power-on term is true for one cycle only.
    assign start_reset = (por_cnt_reg >= 32'(POR_CYCLES - 1) && !por_done_reg)
        || !pin_sync_reg || (cmd_take && cmd_sys_reset);

    // The reset process runs a fixed time after its last trigger; a pin
    // held low keeps it restarting, so the device stays in reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            sys_reset_reg <= 1'b1;
            rp_cnt_reg <= 8'h0;
        end else if (start_reset) begin
            sys_reset_reg <= 1'b1;
            rp_cnt_reg <= 8'h0;
        end else if (sys_reset_reg && por_done_reg) begin
            if (rp_cnt_reg >= 8'(RESET_PROC_CYC - 1)) begin
                sys_reset_reg <= 1'b0;
            end else begin
                rp_cnt_reg <= rp_cnt_reg + 8'h1;
            end
        end
    end

    // Both status bits follow the reset process.
    assign reset_in_progress_flag = sys_reset_reg;
    assign busy_flag = sys_reset_reg;

    // ****************************************
    // Control registers
    // ****************************************

    // Every setting returns to default while reset runs.
    // The request edge clears them too, so the defaults
    // show on the cycle after it.
    always_ff @(posedge clock) begin
        if (rst || sys_reset_reg || start_reset) begin
            mux_rate_setting <= MUX_RATE_RST;
            scan_start_line <= START_LINE_RST;
            row_mirror <= MIRROR_RST;
        end else if (cmd_take) begin
            if (cmd_set_mux) begin
                mux_rate_setting <= cmd_arg[1:0];
            end
            if (cmd_set_start) begin
                scan_start_line <= cmd_arg[6:0];
            end
            if (cmd_set_map) begin
                // Only the read mapping moves; RAM is not touched.
                row_mirror <= cmd_arg[3];
            end
        end
    end

    // The driver field steers the mode: all off sleeps, all on runs.
    // A reset request beats an enable command taken
    // in the same cycle.
    always_ff @(posedge clock) begin
        if (rst || sys_reset_reg || start_reset) begin
            driver_enable_field <= DRV_EN_RST;
            operating_mode_field <= LSPM_MODE_RESET;
        end else if (cmd_take && cmd_set_enable) begin
            driver_enable_field <= cmd_arg[4:2];
            if (cmd_arg[4:2] == DRV_ALL_OFF) begin
                operating_mode_field <= LSPM_MODE_SLEEP;
            end else if (cmd_arg[4:2] == DRV_ALL_ON) begin
                operating_mode_field <= LSPM_MODE_NORMAL;
            end else if (operating_mode_field == LSPM_MODE_RESET) begin
                // A partial field leaves reset for sleep, keeping the
                // draining circuit off once software has taken over.
                operating_mode_field <= LSPM_MODE_SLEEP;
            end
        end
    end

    // ****************************************
    // Power and driver gating
    // ****************************************

    // Readiness is rechecked each time the device enters normal mode.
    // A supply dip in normal mode is not seen; only
    // leaving normal mode rearms the check.
    always_ff @(posedge clock) begin
        if (rst || operating_mode_field != LSPM_MODE_NORMAL) begin
            ready_reg <= 1'b0;
        end else if (supplies_ready) begin
            ready_reg <= 1'b1;
        end
    end

    // The enables follow the mode table directly.
    always_comb begin
        display_clk_en = (operating_mode_field == LSPM_MODE_NORMAL);
        pump_en = (operating_mode_field == LSPM_MODE_NORMAL);
        // Sleep keeps the capacitors charged; only reset drains.
        drain_en = (operating_mode_field == LSPM_MODE_RESET);
        drivers_active = display_clk_en && ready_reg;
    end

    // ****************************************
    // Status answer
    // ****************************************

    // Status reads are answered one cycle after being taken.
    // The word is captured at the take edge, before
    // a reset starting then can show in it.
    always_ff @(posedge clock) begin
        if (rst) begin
            status_valid <= 1'b0;
            status_data <= 4'h0;
        end else begin
            status_valid <= cmd_take && cmd_is_status_read;
            status_data <= {sys_reset_reg, sys_reset_reg,
                operating_mode_field};
        end
    end

    // ****************************************
    // Row timing and line generator
    // ****************************************

    // The row divider only runs with the display clock.
    // A row_div of zero ticks on every clock.
    always_ff @(posedge clock) begin
        if (rst || !display_clk_en) begin
            div_cnt_reg <= 8'h0;
            row_tick <= 1'b0;
        end else if (div_cnt_reg >= row_div) begin
            div_cnt_reg <= 8'h0;
            row_tick <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h1;
            row_tick <= 1'b0;
        end
    end

    // The scan restarts from row zero whenever the
    // drivers drop, since run falls with them.
    lspm_line_gen u_line (
        .clock(clock),
        .rst(rst),
        .run(drivers_active),
        .row_tick(row_tick),
        .mux_rate_setting(mux_rate_setting),
        .scan_start_line(scan_start_line),
        .row_mirror(row_mirror),
        .row_index(row_index),
        .ram_line(ram_line),
        .field_start(field_start)
    );

    // ****************************************
    // Checks
    // ****************************************

    // The pin check starts at the raw pin, so the
    // two-flop delay is covered as well.

    // Pin sampled low, then two clocks of synchroniser.
    sequence s_pin_synced;
        !reset_pin_n ##1 1'b1 ##1 1'b1;
    endsequence

    // An enable command taken with no reset pending.
    sequence s_enable_taken;
        cmd_take && cmd_set_enable && !start_reset && !sys_reset_reg;
    endsequence

    // A refused mux command must leave the mux setting alone.
    a_reset_ignores: assert property (
        @(posedge clock) disable iff (rst)
        (sys_reset_reg && cmd_valid && !cmd_is_status_read && cmd_set_mux
         && !start_reset)
        |=> $stable(mux_rate_setting))
        else $error("command taken during reset");

    // A status read is answered even while reset runs.
    a_status_answer: assert property (
        @(posedge clock) disable iff (rst)
        cmd_valid && cmd_is_status_read |=> status_valid)
        else $error("status read not answered");

    // Any reset request shows flags and Reset mode next.
    a_flags_mode: assert property (
        @(posedge clock) disable iff (rst)
        start_reset |=> reset_in_progress_flag && busy_flag
        && operating_mode_field == LSPM_MODE_RESET)
        else $error("reset flags or mode wrong");

    // The synchronised pin starts a reset.
    a_pin_reset: assert property (
        @(posedge clock) disable iff (rst)
        s_pin_synced |=> reset_in_progress_flag)
        else $error("pin did not reset");

    // An all-off driver field puts the device to sleep.
    a_enable_sleep: assert property (
        @(posedge clock) disable iff (rst)
        s_enable_taken ##0 (cmd_arg[4:2] == DRV_ALL_OFF)
        |=> operating_mode_field == LSPM_MODE_SLEEP)
        else $error("sleep not entered");

    // An all-on driver field runs the display.
    a_enable_normal: assert property (
        @(posedge clock) disable iff (rst)
        s_enable_taken ##0 (cmd_arg[4:2] == DRV_ALL_ON)
        |=> operating_mode_field == LSPM_MODE_NORMAL)
        else $error("normal not entered");

    // Only Reset drains and only Normal pumps.
    a_drain_only: assert property (
        @(posedge clock) disable iff (rst)
        drain_en == (operating_mode_field == LSPM_MODE_RESET)
        && pump_en == (operating_mode_field == LSPM_MODE_NORMAL))
        else $error("drain or pump wrong for mode");

    // Drivers come up only after the supplies were ready.
    a_drv_ready: assert property (
        @(posedge clock) disable iff (rst)
        $rose(drivers_active) |-> $past(supplies_ready))
        else $error("drivers active before ready");

    // While reset runs the settings sit at their defaults.
    a_defaults: assert property (
        @(posedge clock) disable iff (rst)
        sys_reset_reg |=> !row_mirror && scan_start_line == START_LINE_RST
        && mux_rate_setting == MUX_RATE_RST)
        else $error("defaults not restored");

endmodule

/* File: sim/lspm_host_model.sv */
// Host microcontroller model that drives commands into the controller.
module lspm_host_model (
    input wire logic clock, // System clock.
    input wire logic reset_in_progress_flag, // Device reset status.
    output logic cmd_valid, // Command strobe.
    output logic [5:0] cmd_kind, // One-hot command kind.
    output logic [7:0] cmd_arg // Command argument.
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle values at time zero; the strobe starts low.
    initial begin
        cmd_valid = 1'b0;
        cmd_kind = 6'h00;
        cmd_arg = 8'h00;
    end

    // One command per strobe, held over one whole clock cycle.
    // Between commands the qualifiers show the inverse of the last value,
    // so a design that samples them without the strobe sees junk.
    task automatic send(input logic [5:0] kind, input logic [7:0] arg);
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd_kind = kind;
        cmd_arg = arg;
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        cmd_kind = ~kind;
        cmd_arg = ~arg;
    endtask

    // Poll until the reset process has finished, under a bound.
    task automatic wait_ready(output int n);
        n = 0;
        while (reset_in_progress_flag !== 1'b0 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    // Hold off after a system reset so the capacitors can drain.
    task automatic drain_wait(input int cycles);
        repeat (cycles) @(posedge clock);
    endtask
endmodule

/* File: sim/lspm_ctrl_bench.sv */
// Self-checking bench for the LCD scan and power mode controller.
module lspm_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import lspm_pkg::*;

    // ****************************************
    // Signals, stimulus state and tallies
    // ****************************************
    localparam logic [5:0] K_STAT = 6'h20; // Status read.
    localparam logic [5:0] K_RST = 6'h10; // System reset.
    localparam logic [5:0] K_MUX = 6'h08; // Set mux rate.
    localparam logic [5:0] K_START = 6'h04; // Set start line.
    localparam logic [5:0] K_MAP = 6'h02; // Set mapping bits.
    localparam logic [5:0] K_EN = 6'h01; // Set driver field.
    logic clock = 1'b0, rst = 1'b1, reset_pin_n = 1'b1;
    logic supplies_ready = 1'b0;
    logic [7:0] row_div = 8'h01;
    logic cmd_valid, status_valid, reset_in_progress_flag, busy_flag;
    logic [5:0] cmd_kind;
    logic [7:0] cmd_arg, row_index, prev_row, gap;
    logic [3:0] status_data;
    lspm_mode_e operating_mode_field;
    logic [1:0] mux_rate_setting, e_mux;
    logic [6:0] scan_start_line, ram_line, e_start;
    logic row_mirror, display_clk_en, drivers_active, pump_en, drain_en;
    logic [2:0] driver_enable_field;
    logic row_tick, field_start, e_mir;
    logic chk_on = 1'b0, armed = 1'b0;
    int mismatches = 0, n_compared = 0, cyc = 0, n, i;

    always #20 clock = ~clock;

    // A short power-on wait keeps the run brief.
    lspm_ctrl #(.POR_CYCLES(10)) dut_u (
        .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
        .cmd_valid(cmd_valid), .cmd_is_status_read(cmd_kind[5]),
        .cmd_sys_reset(cmd_kind[4]), .cmd_set_mux(cmd_kind[3]),
        .cmd_set_start(cmd_kind[2]), .cmd_set_map(cmd_kind[1]),
        .cmd_set_enable(cmd_kind[0]), .cmd_arg(cmd_arg),
        .row_div(row_div), .supplies_ready(supplies_ready),
        .status_valid(status_valid), .status_data(status_data),
        .reset_in_progress_flag(reset_in_progress_flag),
        .busy_flag(busy_flag), .operating_mode_field(operating_mode_field),
        .mux_rate_setting(mux_rate_setting),
        .scan_start_line(scan_start_line), .row_mirror(row_mirror),
        .driver_enable_field(driver_enable_field),
        .display_clk_en(display_clk_en), .drivers_active(drivers_active),
        .pump_en(pump_en), .drain_en(drain_en), .row_tick(row_tick),
        .row_index(row_index), .ram_line(ram_line),
        .field_start(field_start));

    lspm_host_model host_u (.clock(clock),
        .reset_in_progress_flag(reset_in_progress_flag),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_arg(cmd_arg));

    // ****************************************
    // Expectations and comparison helpers
    // ****************************************
    function automatic logic [7:0] rows_of(input logic [1:0] m);
        case (m)
            2'h0: return MUX_64;
            2'h1: return MUX_80;
            2'h2: return MUX_102;
            default: return MUX_128;
        endcase
    endfunction

    // RAM line for a physical row; the 7-bit slice gives the modulo 128.
    function automatic logic [6:0] exp_line(input logic [7:0] r);
        logic [7:0] v;
        v = e_mir ? {1'b0, e_start} + rows_of(e_mux) - 8'h01 - r
                  : {1'b0, e_start} + r;
        return v[6:0];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Mode code plus the clock, pump and drain enables that go with it.
    task automatic chk_mode(input logic [1:0] m);
        logic [2:0] e;
        e = (m == 2'b11) ? 3'b110 : ((m == 2'b00) ? 3'b001 : 3'b000);
        chk({6'h0, operating_mode_field}, {6'h0, m});
        chk({5'h0, display_clk_en, pump_en, drain_en}, {5'h0, e});
    endtask

    task automatic chk_status(input logic [3:0] e);
        host_u.send(K_STAT, 8'h00);
        chk({3'h0, status_valid, status_data}, {4'h1, e});
    endtask

    task automatic test_done;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Scan monitor: row order, row period and RAM line per row.
    always @(posedge clock) begin
        #2;
        gap = gap + 8'h01;
        if (chk_on && row_index !== prev_row) begin
            if (armed) begin
                chk(row_index, (prev_row + 8'h01 == rows_of(e_mux)) ?
                    8'h00 : prev_row + 8'h01);
                chk(gap, row_div + 8'h01);
            end
            armed = 1'b1;
            gap = 8'h00;
        end
        if (chk_on) begin
            chk({1'b0, ram_line}, {1'b0, exp_line(row_index)});
        end else begin
            armed = 1'b0;
        end
        prev_row = row_index;
    end

    // Hang guard: the tests take well under this many cycles.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hc466));
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        // While reset runs only the status read is answered.
        chk_status(4'hc);
        host_u.send(K_START, 8'h05);
        host_u.send(K_EN, 8'h1c);
        host_u.wait_ready(n);
        chk({7'h0, n >= 16 && n <= 40}, 8'h01);
        chk({1'b0, scan_start_line}, 8'h00);
        chk({mux_rate_setting, row_mirror, driver_enable_field}, 8'h30);
        chk_mode(2'b00);
        // Normal mode with drivers held idle until the supplies settle.
        host_u.send(K_EN, 8'h1c);
        chk_mode(2'b11);
        chk({7'h0, drivers_active}, 8'h00);
        supplies_ready = 1'b1;
        repeat (3) @(posedge clock);
        chk({7'h0, drivers_active}, 8'h01);
        host_u.send(K_EN, 8'h14);
        chk_mode(2'b11);
        // Brief sleep keeps the charge; no drain.
        host_u.send(K_EN, 8'h00);
        chk_mode(2'b10);
        supplies_ready = 1'b0;
        host_u.send(K_EN, 8'h1c);
        repeat (3) @(posedge clock);
        #1;
        chk({7'h0, drivers_active}, 8'h00);
        supplies_ready = 1'b1;
        // Every mux setting, a top start line, both mirror settings.
        for (i = 0; i < 6; i++) begin
            e_mux = (i < 4) ? i[1:0] : 2'($urandom_range(0, 3));
            e_start = (i == 1) ? 7'h7f : 7'($urandom_range(0, 127));
            e_mir = (i < 2) ? i[0] : 1'($urandom_range(0, 1));
            host_u.send(K_MUX, {6'h0, e_mux});
            host_u.send(K_START, {1'b0, e_start});
            host_u.send(K_MAP, {4'h0, e_mir, 3'h0});
            row_div = 8'($urandom_range(0, 2));
            repeat (400) @(posedge clock);
            chk({7'h0, field_start}, {7'h0, row_index == 8'h00});
            chk_on = 1'b1;
            repeat (132 * (row_div + 1)) @(posedge clock);
            chk_on = 1'b0;
        end
        chk_status(4'h3);
        // System reset command from normal with altered settings.
        host_u.send(K_RST, 8'h00);
        chk({6'h0, reset_in_progress_flag, busy_flag}, 8'h03);
        chk_mode(2'b00);
        chk_status(4'hc);
        host_u.send(K_MUX, 8'h00);
        chk({mux_rate_setting, row_mirror, driver_enable_field}, 8'h30);
        host_u.wait_ready(n);
        chk({7'h0, n >= 8 && n <= 25}, 8'h01);
        host_u.drain_wait(25);
        // Reset pin pulled low from normal mode.
        host_u.send(K_EN, 8'h1c);
        host_u.send(K_START, 8'h09);
        reset_pin_n = 1'b0;
        repeat (5) @(posedge clock);
        chk({6'h0, reset_in_progress_flag, busy_flag}, 8'h03);
        repeat (30) @(posedge clock);
        chk_status(4'hc);
        chk_mode(2'b00);
        chk({1'b0, scan_start_line}, 8'h00);
        reset_pin_n = 1'b1;
        host_u.wait_ready(n);
        chk({7'h0, n >= 16 && n <= 25}, 8'h01);
        test_done();
    end
endmodule
